// ==== hdl/reading_offset_and_average_filter.sv ====
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "filter_active_indicator_params.svh"

module reading_offset_and_average_filter
  import filter_active_indicator_pkg::*;
#(
  parameter int AVG_DEPTH = 100
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire reading_type rd_in,
  output logic             null_request,
  output corr_type         out_rd,
  output logic             filter_active_indicator,
  output logic      [10:0] power_line_cycles,
  output logic      [7:0]  ac_low_limit_hz,
  output logic      [7:0]  ac_settle_tenths
);

  localparam int SUM_W = CORR_W + 7;  // 100 full-scale readings fit

  if (AVG_DEPTH < 100 || AVG_DEPTH > 127) begin : g_bad_depth
    $error("AVG_DEPTH must be 100 to 127");
  end

  // Resolution table: {auto on, integration time}
  function automatic logic [11:0] res_table(input logic [2:0] res);
    logic [11:0] r;
    r = {1'b1, `PLC_1};
    case (res)
      RES_FAST_45: r = {1'b0, `PLC_0P02};
      RES_SLOW_45: r = {1'b1, `PLC_0P1};
      RES_FAST_55: r = {1'b0, `PLC_0P1};
      RES_SLOW_55: r = {1'b1, `PLC_1};
      RES_FAST_65: r = {1'b1, `PLC_1};
      RES_SLOW_65: r = {1'b1, `PLC_10};
      default:     r = {1'b1, `PLC_1};
    endcase
    return r;
  endfunction

  // Averaging bypassed for these functions
  function automatic logic no_avg(input logic [3:0] fn);
    return fn == FN_FREQ || fn == FN_PERIOD || fn == FN_CONT || fn == FN_DIODE;
  endfunction

  // Settings
  logic [2:0]  res_q;
  logic [3:0]  func_q;
  logic [1:0]  bw_q;
  logic [1:0]  zero_q;
  logic [1:0]  gain_q;
  logic        en_q;
  logic        mode_q;
  logic [6:0]  count_q;
  logic [31:0] rdata_q;
  logic        first_q;

  // Filter state
  logic signed [CORR_W-1:0] mem [0:AVG_DEPTH-1];
  logic signed [SUM_W-1:0]  sum_q;
  logic signed [CORR_W-1:0] seed_q;
  logic [6:0]               idx_q;
  logic [6:0]               written_q;
  logic                     started_q;
  corr_type                 out_q;
  corr_type                 corr;

  // Bus decode
  wire wr_cfg  = wr && addr == `ADDR_CONFIG;
  wire wr_adc  = wr && addr == `ADDR_ADC;
  wire wr_flt  = wr && addr == `ADDR_FILTER;
  wire wr_tog  = wr && addr == `ADDR_TOGGLE;

  // Write fields
  wire [2:0] w_res   = wdata[`CFG_RES_LSB +: 3];
  wire [3:0] w_func  = wdata[`CFG_FUNC_LSB +: 4];
  wire [1:0] w_bw    = wdata[`CFG_BW_LSB +: 2];
  wire [1:0] w_zero  = wdata[`ADC_ZERO_LSB +: 2];
  wire [1:0] w_gain  = wdata[`ADC_GAIN_LSB +: 2];
  wire [6:0] w_count = wdata[`FLT_COUNT_LSB +: 7];
  wire       w_mode  = wdata[`FLT_MODE_BIT];
  wire       w_en    = wdata[`FLT_EN_BIT];

  // Legal value checks; illegal fields keep their old value
  wire res_ok   = w_res <= 3'h5;
  wire bw_ok    = w_bw != 2'h3;
  wire count_ok = w_count >= `AVG_MIN && w_count <= `AVG_MAX;
  wire [11:0] w_tab = res_table(w_res);
  wire [1:0]  tab_zg = w_tab[11] ? ZG_ON : ZG_OFF;

  // Once is a trigger, stored as off afterwards
  wire zero_once = wr_adc && w_zero == ZG_ONCE;
  wire gain_once = wr_adc && w_gain == ZG_ONCE;
  wire once_pulse = zero_once | gain_once;
  wire func_chg   = wr_cfg && w_func != func_q;
  wire res_chg    = wr_cfg && res_ok && w_res != res_q;
  wire change_pulse = func_chg | res_chg;

  // Restart when anything shaping the average moves
  wire count_chg = wr_flt && count_ok && w_count != count_q;
  wire mode_chg  = wr_flt && w_mode != mode_q;
  wire en_chg    = (wr_flt && w_en != en_q) || wr_tog;
  wire restart   = count_chg | mode_chg | func_chg | en_chg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_q   <= `RST_RESOLUTION;
      func_q  <= `RST_FUNCTION;
      bw_q    <= `RST_AC_BW;
      zero_q  <= ZG_ON;
      gain_q  <= ZG_ON;
      en_q    <= `RST_FILTER_ACTIVE_INDICATOR_EN;
      mode_q  <= `RST_FILTER_ACTIVE_INDICATOR_MODE;
      count_q <= `RST_AVG_COUNT;
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
      if (wr_cfg) begin
        func_q <= w_func;
        if (res_ok) begin
          res_q <= w_res;
        end
        if (bw_ok) begin
          bw_q <= w_bw;
        end
      end
      if (res_chg) begin
        zero_q <= tab_zg;
        gain_q <= tab_zg;
      end else if (wr_adc) begin
        if (w_zero != 2'h3) begin
          zero_q <= zero_once ? ZG_OFF : w_zero;
        end
        if (w_gain != 2'h3) begin
          gain_q <= gain_once ? ZG_OFF : w_gain;
        end
      end
      if (wr_flt) begin
        mode_q <= w_mode;
        if (count_ok) begin
          count_q <= w_count;
        end
      end
      if (wr_tog) begin
        en_q <= ~en_q;
      end else if (wr_flt) begin
        en_q <= w_en;
      end
    end
  end

  // Offset subtraction and null sequencing
  wire auto_on = zero_q == ZG_ON || gain_q == ZG_ON;

  offset_null u_null (
    .clk          (clk),
    .resetn       (resetn),
    .rd_in        (rd_in),
    .auto_on      (auto_on),
    .once_pulse   (once_pulse),
    .change_pulse (change_pulse),
    .null_request (null_request),
    .corr_out     (corr)
  );

  // Averaging datapath
  wire bypass = ~en_q | no_avg(func_q);
  wire take   = corr.valid & ~bypass & ~restart;
  wire [6:0] last_idx = count_q - 7'h01;
  wire wrap   = idx_q == last_idx;
  wire signed [SUM_W-1:0] x_ext   = SUM_W'(corr.value);
  wire signed [SUM_W-1:0] cnt_ext = SUM_W'({1'b0, count_q});
  // Unwritten slots hold the seed, so the store needs no fill loop
  wire signed [CORR_W-1:0] old_rd = (idx_q < written_q) ? mem[idx_q] : seed_q;
  wire signed [SUM_W-1:0] old_ext = SUM_W'(old_rd);
  wire signed [SUM_W-1:0] seed_sum  = x_ext * cnt_ext;
  wire signed [SUM_W-1:0] slide_sum = sum_q - old_ext + x_ext;
  wire signed [SUM_W-1:0] block_sum = sum_q + x_ext;
  wire signed [SUM_W-1:0] new_sum = mode_q ? block_sum
                                  : (started_q ? slide_sum : seed_sum);
  wire signed [SUM_W-1:0] quot = new_sum / cnt_ext;
  wire block_done = mode_q & wrap;
  wire emit_avg   = take & (~mode_q | block_done);
  wire [6:0] next_idx = wrap ? 7'h00 : idx_q + 7'h01;

  // Store write; contents need no reset
  wire mem_we = take & ~mode_q;
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[idx_q] <= corr.value;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sum_q     <= '0;
      seed_q    <= '0;
      idx_q     <= 7'h00;
      written_q <= 7'h00;
      started_q <= 1'b0;
    end else if (restart) begin
      sum_q     <= '0;
      idx_q     <= 7'h00;
      written_q <= 7'h00;
      started_q <= 1'b0;
    end else if (take) begin
      idx_q     <= next_idx;
      sum_q     <= block_done ? '0 : new_sum;
      started_q <= ~mode_q;
      if (!mode_q && !started_q) begin
        seed_q <= corr.value;
      end
      if (!mode_q && idx_q >= written_q) begin
        written_q <= idx_q + 7'h01;
      end
    end
  end

  // Result register; a reading arriving on a restart cycle is dropped unless bypass passes it straight through
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= '0;
    end else begin
      out_q.valid <= 1'b0;
      if (corr.valid && bypass) begin
        out_q.valid <= 1'b1;
        out_q.value <= corr.value;
      end else if (emit_avg) begin
        out_q.valid <= 1'b1;
        out_q.value <= quot[CORR_W-1:0];
      end
    end
  end

  // Table lookups for outputs and status
  wire [11:0] cur_tab = res_table(res_q);
  wire [7:0]  bw_hz   = bw_q == BW_SLOW ? `BW_SLOW_HZ
                      : (bw_q == BW_FAST ? `BW_FAST_HZ : `BW_MED_HZ);
  wire [7:0]  settle  = bw_q == BW_SLOW ? `SETTLE_SLOW
                      : (bw_q == BW_FAST ? `SETTLE_FAST : `SETTLE_MED);

  // Read mux; unmapped offsets read zero
  wire [31:0] cfg_word = {22'h00_0000, bw_q, 1'b0, func_q, res_q};
  wire [31:0] adc_word = {28'h000_0000, gain_q, zero_q};
  wire [31:0] flt_word = {17'h0_0000, count_q, 6'h00, mode_q, en_q};
  wire [31:0] res_word = 32'(out_q.value);
  wire [31:0] sts_word = {1'b0, written_q, settle, 5'h00, cur_tab[10:0]};
  wire [31:0] rd_mux = addr == `ADDR_CONFIG ? cfg_word
                     : addr == `ADDR_ADC    ? adc_word
                     : addr == `ADDR_FILTER ? flt_word
                     : addr == `ADDR_RESULT ? res_word
                     : addr == `ADDR_STATUS ? sts_word
                     : 32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata                   = rdata_q;
  assign out_rd                  = out_q;
  assign filter_active_indicator = en_q;
  assign power_line_cycles       = cur_tab[10:0];
  assign ac_low_limit_hz         = bw_hz;
  assign ac_settle_tenths        = settle;

  // Checks
  chk_reset_defaults: assert property (@(posedge clk) disable iff (!resetn)
    first_q |-> auto_on && bw_q == BW_MED && en_q && !mode_q && count_q == 7'h0a)
    else $error("power-on settings wrong");

  chk_toggle_press: assert property (@(posedge clk) disable iff (!resetn)
    wr_tog |=> filter_active_indicator != $past(filter_active_indicator))
    else $error("enable press did not toggle");

  chk_count_refused: assert property (@(posedge clk) disable iff (!resetn)
    wr_flt && (w_count < 7'h02 || w_count > 7'h64) |=> $stable(count_q))
    else $error("illegal count accepted");

  chk_fast45_table: assert property (@(posedge clk) disable iff (!resetn)
    wr_cfg && w_res == RES_FAST_45 && w_res != res_q
      |=> !auto_on && power_line_cycles == 11'h002)
    else $error("fast 4.5 settings wrong");

  chk_first_fills: assert property (@(posedge clk) disable iff (!resetn)
    take && !mode_q && !started_q
      |=> out_rd.valid && out_rd.value == $past(corr.value))
    else $error("first sliding output is not the reading");

  chk_block_emit: assert property (@(posedge clk) disable iff (!resetn)
    take && mode_q |=> out_rd.valid == $past(wrap))
    else $error("block output not once per count");

  // Store must start empty after each block result
  chk_block_flush: assert property (@(posedge clk) disable iff (!resetn)
    take && block_done && !restart |=> sum_q == '0 && idx_q == 7'h00)
    else $error("block store not flushed");

  chk_restart_clear: assert property (@(posedge clk) disable iff (!resetn)
    restart |=> idx_q == 7'h00 && written_q == 7'h00 && !started_q && sum_q == '0)
    else $error("store not cleared on change");

  chk_bypass_pass: assert property (@(posedge clk) disable iff (!resetn)
    corr.valid && no_avg(func_q) |=> out_rd.valid && out_rd.value == $past(corr.value))
    else $error("bypass reading altered");

  chk_avg_lit: assert property (@(posedge clk) disable iff (!resetn)
    emit_avg |=> filter_active_indicator)
    else $error("averaged output with indicator dark");

  cov_sliding_out: cover property (@(posedge clk) disable iff (!resetn)
    take && !mode_q && started_q);
  cov_block_out: cover property (@(posedge clk) disable iff (!resetn)
    take && block_done);
  cov_bypass_out: cover property (@(posedge clk) disable iff (!resetn)
    corr.valid && bypass);

endmodule // reading_offset_and_average_filter

`default_nettype wire

// ==== inc/filter_active_indicator_params.svh ====
`ifndef FILTER_ACTIVE_INDICATOR_PARAMS_SVH
`define FILTER_ACTIVE_INDICATOR_PARAMS_SVH

// Register byte offsets
`define ADDR_CONFIG       8'h00
`define ADDR_ADC          8'h04
`define ADDR_FILTER       8'h08
`define ADDR_TOGGLE       8'h0c
`define ADDR_RESULT       8'h10
`define ADDR_STATUS       8'h14

// Field positions
`define CFG_RES_LSB       0
`define CFG_FUNC_LSB      3
`define CFG_BW_LSB        8
`define ADC_ZERO_LSB      0
`define ADC_GAIN_LSB      2
`define FLT_EN_BIT        0
`define FLT_MODE_BIT      1
`define FLT_COUNT_LSB     8
`define STS_PLC_LSB       0
`define STS_SETTLE_LSB    16
`define STS_FILL_LSB      24

// Power-on values
`define RST_RESOLUTION    3'h3
`define RST_FUNCTION      4'h0
`define RST_AC_BW         2'h1
`define RST_FILTER_ACTIVE_INDICATOR_EN       1'b1
`define RST_FILTER_ACTIVE_INDICATOR_MODE     1'b0
`define RST_AVG_COUNT     7'h0a

// Averaging count limits
`define AVG_MIN           7'h02
`define AVG_MAX           7'h64

// Integration time in hundredths of a line cycle
`define PLC_0P02          11'h002
`define PLC_0P1           11'h00a
`define PLC_1             11'h064
`define PLC_10            11'h3e8

// Lower bandwidth limit in Hz and settling in tenths of a second
`define BW_SLOW_HZ        8'h03
`define BW_MED_HZ         8'h14
`define BW_FAST_HZ        8'hc8
`define SETTLE_SLOW       8'h46
`define SETTLE_MED        8'h0a
`define SETTLE_FAST       8'h01

`endif

// ==== inc/filter_active_indicator_pkg.sv ====
package filter_active_indicator_pkg;

  localparam int READ_W = 24;
  localparam int CORR_W = READ_W + 1;

  typedef enum logic [2:0] {
    RES_FAST_45 = 3'b000,
    RES_SLOW_45 = 3'b001,
    RES_FAST_55 = 3'b010,
    RES_SLOW_55 = 3'b011,
    RES_FAST_65 = 3'b100,
    RES_SLOW_65 = 3'b101
  } resolution_type;

  typedef enum logic [1:0] {
    ZG_OFF  = 2'b00,
    ZG_ONCE = 2'b01,
    ZG_ON   = 2'b10
  } zg_mode_type;

  typedef enum logic [1:0] {
    BW_SLOW = 2'b00,
    BW_MED  = 2'b01,
    BW_FAST = 2'b10
  } ac_bw_type;

  // Measurement functions; codes 0xb..0xf unused
  localparam logic [3:0] FN_FREQ   = 4'h6;
  localparam logic [3:0] FN_PERIOD = 4'h7;
  localparam logic [3:0] FN_CONT   = 4'h8;
  localparam logic [3:0] FN_DIODE  = 4'h9;

  typedef struct packed {
    logic                     valid;
    logic                     null_rd;
    logic signed [READ_W-1:0] value;
  } reading_type;

  typedef struct packed {
    logic                     valid;
    logic signed [CORR_W-1:0] value;
  } corr_type;

endpackage

// ==== hdl/offset_null.sv ====
`timescale 1ns/10ps
`default_nettype none

module offset_null
  import filter_active_indicator_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire reading_type rd_in,
  input  wire logic        auto_on,
  input  wire logic        once_pulse,
  input  wire logic        change_pulse,
  output logic             null_request,
  output corr_type         corr_out
);

  typedef enum logic {
    ST_IDLE      = 1'b0,
    ST_WAIT_NULL = 1'b1
  } null_state_type;

  null_state_type           state_q;
  null_state_type           state_d;
  logic signed [READ_W-1:0] offset_q;
  logic signed [READ_W-1:0] base_q;
  logic                     req_q;
  corr_type                 corr_q;

  // Input decode
  wire base_in = rd_in.valid & ~rd_in.null_rd;
  wire null_in = rd_in.valid & rd_in.null_rd;
  wire take_new = base_in & auto_on & (state_q == ST_IDLE);
  wire req_set = take_new | once_pulse | change_pulse;

  // Set wins over the clear by the arriving null reading
  wire req_d = req_set | (req_q & ~null_in);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:      if (take_new) begin
        state_d = ST_WAIT_NULL;
      end
      ST_WAIT_NULL: if (null_in) begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Base minus most recent null
  wire signed [CORR_W-1:0] held_diff = CORR_W'(base_q) - CORR_W'(rd_in.value);
  wire signed [CORR_W-1:0] live_diff = CORR_W'(rd_in.value) - CORR_W'(offset_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= ST_IDLE;
      offset_q <= '0;
      base_q   <= '0;
      req_q    <= 1'b0;
      corr_q   <= '0;
    end else begin
      state_q      <= state_d;
      req_q        <= req_d;
      corr_q.valid <= 1'b0;
      if (null_in) begin
        offset_q <= rd_in.value;
      end
      if (take_new) begin
        base_q <= rd_in.value;
      end
      if (null_in && state_q == ST_WAIT_NULL) begin
        corr_q.valid <= 1'b1;
        corr_q.value <= held_diff;
      end else if (base_in && !auto_on) begin
        corr_q.valid <= 1'b1;
        corr_q.value <= live_diff;
      end
    end
  end

  assign null_request = req_q;
  assign corr_out     = corr_q;

  chk_fresh_null: assert property (@(posedge clk) disable iff (!resetn)
    take_new |=> null_request && state_q == ST_WAIT_NULL)
    else $error("no offset request after base reading");

endmodule // offset_null

`default_nettype wire

// ==== testbench/converter_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module converter_model
  import filter_active_indicator_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              null_request,
  input  wire logic              base_go,
  input  wire logic [READ_W-1:0] base_val,
  input  wire logic [READ_W-1:0] null_val,
  input  wire logic [3:0]        null_wait,
  output reading_type            rd_in
);
  logic [3:0] wait_q;
  logic [1:0] guard_q;

  // Null answered after null_wait cycles; guard blocks a second answer
  // while the request is still falling
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_in   <= '0;
      wait_q  <= '0;
      guard_q <= '0;
    end else begin
      rd_in.valid   <= 1'b0;
      rd_in.null_rd <= 1'b0;
      rd_in.value   <= ~rd_in.value;  // Idle data never holds its last value
      if (guard_q != 2'h0) begin
        guard_q <= guard_q - 2'h1;
      end
      if (base_go) begin
        rd_in <= {1'b1, 1'b0, base_val};
      end else if (null_request && guard_q == 2'h0) begin
        if (wait_q == null_wait) begin
          rd_in   <= {1'b1, 1'b1, null_val};
          wait_q  <= '0;
          guard_q <= 2'h3;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule  // converter_model

`default_nettype wire

// ==== testbench/reading_offset_and_average_filter_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "filter_active_indicator_params.svh"

module reading_offset_and_average_filter_bench
  import filter_active_indicator_pkg::*;
;
  logic clk, resetn, wr, rd, base_go, null_request, filter_active_indicator;
  logic [7:0] addr, ac_low_limit_hz, ac_settle_tenths;
  logic [31:0] wdata, rdata, seed;
  logic [READ_W-1:0] base_val, null_val, cur_null;
  logic [3:0] null_wait;
  logic [10:0] power_line_cycles;
  reading_type rd_in;
  corr_type out_rd;
  logic signed [CORR_W-1:0] got_q[$], exp_q[$], hist[$];
  int n_mismatch, cmp_count, n_avg;
  int n_null, n_seen;
  logic f_en, f_blk, f_byp, auto_ref;
  localparam logic [10:0] CYC [6] = '{`PLC_0P02, `PLC_0P1, `PLC_0P1, `PLC_1, `PLC_1, `PLC_10};
  localparam logic [5:0] AUTO_TAB = 6'b111010;
  localparam logic [7:0] HZ [3] = '{`BW_SLOW_HZ, `BW_MED_HZ, `BW_FAST_HZ};
  localparam logic [7:0] SET [3] = '{`SETTLE_SLOW, `SETTLE_MED, `SETTLE_FAST};
  localparam int BLK_N [3] = '{5, 2, 100};

  reading_offset_and_average_filter DUT (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rd_in(rd_in), .null_request(null_request), .out_rd(out_rd),
    .filter_active_indicator(filter_active_indicator),
    .power_line_cycles(power_line_cycles), .ac_low_limit_hz(ac_low_limit_hz),
    .ac_settle_tenths(ac_settle_tenths));

  converter_model adc (
    .clk(clk), .resetn(resetn), .null_request(null_request), .base_go(base_go),
    .base_val(base_val), .null_val(null_val), .null_wait(null_wait), .rd_in(rd_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Collect every result pulse
  always @(posedge clk) begin
    if (out_rd.valid === 1'b1) got_q.push_back(out_rd.value);
  end

  // Count offset readings handed over, to prove when none was asked for
  always @(posedge clk) begin
    if (rd_in.valid === 1'b1 && rd_in.null_rd === 1'b1) n_null++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference averaging; 64-bit sum so 100 full-scale values never wrap
  function automatic void ref_in(input logic signed [CORR_W-1:0] c);
    longint s;
    s = 0;
    if (!f_en || f_byp) begin
      exp_q.push_back(c);
      return;
    end
    if (!f_blk && hist.size() == 0) repeat (n_avg - 1) hist.push_back(c);
    else if (!f_blk) void'(hist.pop_front());
    hist.push_back(c);
    if (!f_blk || hist.size() == n_avg) begin
      foreach (hist[i]) s += hist[i];
      exp_q.push_back(CORR_W'(s / n_avg));
      if (f_blk) hist.delete();
    end
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Long tail lets any null fetch finish before the next access
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (16) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic set_filter(input logic en, input logic blk, input logic [6:0] n);
    wr_reg(`ADDR_FILTER, {17'h0, n, 6'h0, blk, en});
    f_en = en;
    f_blk = blk;
    n_avg = int'(n);
    hist.delete();
  endtask

  // Fresh random null per reading while auto is on
  task automatic feed(input int n);
    logic [READ_W-1:0] b;
    repeat (n) begin
      b = READ_W'(rnd());
      @(posedge clk);
      base_go <= 1'b1;
      base_val <= b;
      null_wait <= 4'(rnd()) & 4'h7;
      if (auto_ref) begin
        cur_null = READ_W'(rnd());
        null_val <= cur_null;
      end
      @(posedge clk);
      base_go <= 1'b0;
      ref_in($signed({b[READ_W-1], b}) - $signed({cur_null[READ_W-1], cur_null}));
      repeat (14) @(posedge clk);
    end
  endtask

  task automatic compare_out();
    repeat (4) @(posedge clk);
    chk(got_q.size(), exp_q.size());
    while (got_q.size() > 0 && exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(60000 * 25);
    n_mismatch++;
    final_report();
  end

  initial begin
    {resetn, wr, rd, base_go} = '0;
    {addr, wdata, base_val, null_val, cur_null, null_wait} = '0;
    {n_mismatch, cmp_count} = '0;
    seed = 32'd59;
    {f_en, f_blk, f_byp, auto_ref, n_avg} = {4'b1001, 32'd10};
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(filter_active_indicator, 1);
    chk(power_line_cycles, `PLC_1);
    chk({ac_low_limit_hz, ac_settle_tenths}, {`BW_MED_HZ, `SETTLE_MED});
    rd_chk(`ADDR_CONFIG, 32'h0000_0103);
    rd_chk(`ADDR_ADC, 32'h0000_000a);
    rd_chk(`ADDR_FILTER, 32'h0000_0a01);
    feed(13);
    rd_chk(`ADDR_RESULT, 32'(exp_q[$]));
    rd_chk(`ADDR_STATUS, {8'h0a, `SETTLE_MED, 5'h00, `PLC_1});
    compare_out();
    // Resolution table walked down so the run ends with auto off
    for (int r = 5; r >= 0; r--) begin
      wr_reg(`ADDR_CONFIG, 32'h0000_0100 | 32'(r));
      chk(power_line_cycles, CYC[r]);
      rd_chk(`ADDR_ADC, AUTO_TAB[r] ? 32'h0000_000a : 32'h0);
    end
    auto_ref = 1'b0;
    for (int w = 0; w < 3; w++) begin
      wr_reg(`ADDR_CONFIG, 32'(w) << 8);
      chk({ac_low_limit_hz, ac_settle_tenths}, {HZ[w], SET[w]});
    end
    null_val <= ~cur_null;
    set_filter(1'b1, 1'b0, 7'h04);
    feed(6);
    compare_out();
    n_seen = n_null;
    wr_reg(`ADDR_ADC, 32'h0000_0000);
    chk(null_request, 0);
    chk(n_null, n_seen);
    wr_reg(`ADDR_ADC, 32'h0000_0001);
    chk(n_null, n_seen + 1);
    cur_null = null_val;
    rd_chk(`ADDR_ADC, 32'h0);
    feed(3);
    compare_out();
    foreach (BLK_N[k]) begin
      set_filter(1'b1, 1'b1, 7'(BLK_N[k]));
      feed(2 * BLK_N[k] + 1);
      compare_out();
    end
    wr_reg(`ADDR_FILTER, 32'h0000_0103);
    rd_chk(`ADDR_FILTER, 32'h0000_6403);
    wr_reg(`ADDR_FILTER, 32'h0000_6503);
    rd_chk(`ADDR_FILTER, 32'h0000_6403);
    set_filter(1'b1, 1'b0, 7'h0a);
    for (int fn = 6; fn <= 9; fn++) begin
      n_seen = n_null;
      wr_reg(`ADDR_CONFIG, 32'h0000_0100 | (32'(fn) << 3));
      chk(n_null, n_seen + 1);
      f_byp = 1'b1;
      feed(3);
      compare_out();
    end
    wr_reg(`ADDR_CONFIG, 32'h0000_0100);
    f_byp = 1'b0;
    wr_reg(`ADDR_TOGGLE, 32'h0);
    f_en = 1'b0;
    chk(filter_active_indicator, 0);
    feed(3);
    compare_out();
    wr_reg(`ADDR_TOGGLE, 32'h0);
    f_en = 1'b1;
    hist.delete();
    chk(filter_active_indicator, 1);
    feed(4);
    compare_out();
    final_report();
  end
endmodule  // reading_offset_and_average_filter_bench

`default_nettype wire
